// ===== pwc_regs.svh
// Command codes, status words, field values and timing figures of the password handler.
`ifndef PWC_REGS_SVH
`define PWC_REGS_SVH

// Class and instruction bytes that this handler answers.
`define PWC_CLA_ISO         8'h00
`define PWC_INS_VERIFY      8'h20
`define PWC_INS_CHANGE      8'h24
`define PWC_INS_DISABLE     8'h26
`define PWC_INS_ENABLE      8'h28

// Parameter-byte values that pick the read or the write password.
`define PWC_PW_READ         16'h0001
`define PWC_PW_WRITE        16'h0002
`define PWC_SEL5_READ       5'h01
`define PWC_SEL5_WRITE      5'h02

// Length-byte values.
`define PWC_LC_NONE         8'h00
`define PWC_LC_PW           8'h10

// Status words returned to the host.
`define PWC_SW_OK           16'h9000
`define PWC_SW_UPD_FAIL     16'h6581
`define PWC_SW_PW_REQ       16'h6300
`define PWC_SW_RETRY_BASE   16'h63C0
`define PWC_SW_BAD_STRUCT   16'h6981
`define PWC_SW_SECURITY     16'h6982
`define PWC_SW_COND_USE     16'h6984
`define PWC_SW_BAD_DATA     16'h6A80
`define PWC_SW_NOT_FOUND    16'h6A82
`define PWC_SW_BAD_P1P2     16'h6A86

// Verification attempts allowed in one session.
`define PWC_RETRIES         2'h3

// Kinds of non-volatile write.
`define PWC_NVM_RDPW        2'h0
`define PWC_NVM_WRPW        2'h1
`define PWC_NVM_RIGHTS      2'h2

// Timing: clock rate and response times of the access-right updates.
`define PWC_CLK_MHZ         50
`define PWC_ENABLE_TIME_US  5000
`define PWC_DISABLE_TIME_US 6000
`define PWC_MIN_WAIT        20'h0_0001

`endif

// ===== pwc_pkg.sv
// Types shared by the password handler files.
package pwc_pkg;

	// Which file the session has selected.
	typedef enum logic [1:0] {PWC_FILE_NONE, PWC_FILE_CC, PWC_FILE_NDEF, PWC_FILE_SYS} pwc_file_type;

	// Sequencer states of the handler.
	typedef enum logic [1:0] {PWC_ST_IDLE, PWC_ST_NVM, PWC_ST_HOLD} pwc_state_type;

endpackage

// ===== pwc_delay_timer.sv
`timescale 1ns/1ps
`default_nettype none

// Down-counter that raises expired a loaded number of edges after start.
module pwc_delay_timer #(
	parameter int W = 20
) (
	// Clock and reset.
	input  wire logic         clk,
	input  wire logic         rst,
	// Control.
	input  wire logic         start,
	input  wire logic [W-1:0] loadVal,
	// Status.
	output logic              expired
);

	logic [W-1:0] count_ff;   // Cycles still to wait.
	logic         expired_ff; // Set once the wait has run out.

	// The count is loaded on start and runs down to zero.
	always_ff @(posedge clk)
	begin
		if (rst)
			count_ff <= '0;
		else if (start)
			count_ff <= loadVal;
		else if (count_ff != '0)
			count_ff <= count_ff - {{(W-1){1'b0}}, 1'b1};
	end

	// Expired rises at the edge where the count reaches zero; a load of one waits one edge.
	always_ff @(posedge clk)
	begin
		if (rst)
			expired_ff <= 1'b1;
		else if (start)
			expired_ff <= 1'b0;
		else
			expired_ff <= (count_ff <= {{(W-1){1'b0}}, 1'b1});
	end

	assign expired = expired_ff;

endmodule

`default_nettype wire

// ===== pwc_pw_access_cmd.sv
`timescale 1ns/1ps
`default_nettype none

`include "pwc_regs.svh"

module pwc_pw_access_cmd #(
	parameter int unsigned  ENABLE_CYCLES  = `PWC_ENABLE_TIME_US * `PWC_CLK_MHZ,
	parameter int unsigned  DISABLE_CYCLES = `PWC_DISABLE_TIME_US * `PWC_CLK_MHZ,
	parameter logic [127:0] INIT_READ_PW   = '0,
	parameter logic [127:0] INIT_WRITE_PW  = '0,
	parameter logic         INIT_READ_PROT = 1'b0,
	parameter logic         INIT_WRITE_PROT = 1'b0
) (
	// Clock and reset.
	input  wire logic                 clk,
	input  wire logic                 rst,
	// Session and file selection from the command front end.
	input  wire logic                 sessionStart,
	input  wire pwc_pkg::pwc_file_type fileSel,
	// Decoded command.
	input  wire logic                 cmdValid,
	input  wire logic [7:0]           cmdCla,
	input  wire logic [7:0]           cmdIns,
	input  wire logic [15:0]          cmdP1p2,
	input  wire logic [7:0]           cmdLc,
	input  wire logic [127:0]         cmdData,
	output logic                      cmdReady,
	// Response.
	output logic                      rspValid,
	output logic [15:0]               rspSw,
	// Non-volatile write port.
	output logic                      nvmReq,
	output logic [1:0]                nvmKind,
	output logic [127:0]              nvmData,
	output logic                      nvmReadProt,
	output logic                      nvmWriteProt,
	input  wire logic                 nvmDone,
	input  wire logic                 nvmFail,
	// Access state.
	output logic                      readProtected,
	output logic                      writeProtected,
	output logic                      readGranted,
	output logic                      writeGranted
);

	localparam logic [19:0] ENABLE_WAIT  = ENABLE_CYCLES[19:0];  // Enable response time in cycles.
	localparam logic [19:0] DISABLE_WAIT = DISABLE_CYCLES[19:0]; // Disable response time in cycles.

	pwc_pkg::pwc_state_type state_ff;     // Sequencer state.
	pwc_pkg::pwc_state_type nxt_state;    // Its next value.
	logic [127:0]           readPw_ff;    // Stored read password.
	logic [127:0]           writePw_ff;   // Stored write password.
	logic                   readProt_ff;  // Read access needs a password.
	logic                   writeProt_ff; // Write access needs a password.
	logic                   readGrant_ff; // Read password verified this session.
	logic                   writeGrant_ff; // Write password verified this session.
	logic [1:0]             retries_ff;   // Verification attempts left.
	logic                   cmdReady_ff;  // Handler can take a command.
	logic                   rspValid_ff;  // Response pulse.
	logic [15:0]            rspSw_ff;     // Response status word.
	logic                   nvmReq_ff;    // Write request pulse.
	logic [1:0]             nvmKind_ff;   // What the pending write holds.
	logic [127:0]           nvmData_ff;   // Password of the pending write.
	logic                   nvmRdProt_ff; // Read protection of the pending write.
	logic                   nvmWrProt_ff; // Write protection of the pending write.
	logic                   accept;       // A command of ours is taken this cycle.
	logic                   decRespond;   // Answer at once.
	logic [15:0]            decSw;        // Status of the immediate answer.
	logic                   decNvm;       // Start a non-volatile write.
	logic [1:0]             decKind;      // Kind of that write.
	logic                   decRdProt;    // Read protection to write.
	logic                   decWrProt;    // Write protection to write.
	logic [19:0]            decWait;      // Least wait before the answer.
	logic                   decGrantRd;   // Verify matched the read password.
	logic                   decGrantWr;   // Verify matched the write password.
	logic                   decMiss;      // Verify failed on a wrong password.
	logic [16:0]            gate;         // Common checks: fail flag and status.
	logic                   timerExpired; // Least response time has run out.

	// Checks shared by change, enable and disable: file, structure and security.
	// The status of a CC or system file differs per command, so it is passed in.
	function automatic logic [16:0] pwc_gate_check(input pwc_pkg::pwc_file_type f,
		input logic granted, input logic [15:0] ccSysSw);
		begin
			if (f == pwc_pkg::PWC_FILE_NONE)
				pwc_gate_check = {1'b1, `PWC_SW_NOT_FOUND};
			else if (f != pwc_pkg::PWC_FILE_NDEF)
				pwc_gate_check = {1'b1, ccSysSw};
			else if (!granted)
				pwc_gate_check = {1'b1, `PWC_SW_SECURITY};
			else
				pwc_gate_check = {1'b0, `PWC_SW_OK};
		end
	endfunction

	// Only our class and instructions are taken, and only while idle; anything else is
	// left to the other command handlers of the tag.
	assign accept = cmdValid && cmdReady_ff && (cmdCla == `PWC_CLA_ISO) &&
		((cmdIns == `PWC_INS_VERIFY) || (cmdIns == `PWC_INS_CHANGE) ||
		(cmdIns == `PWC_INS_ENABLE) || (cmdIns == `PWC_INS_DISABLE));

	// Command decode: decides the immediate answer or the write to start.
	always_comb
	begin
		decRespond = 1'b0;
		decSw      = `PWC_SW_OK;
		decNvm     = 1'b0;
		decKind    = `PWC_NVM_RDPW;
		decRdProt  = readProt_ff;
		decWrProt  = writeProt_ff;
		decWait    = `PWC_MIN_WAIT;
		decGrantRd = 1'b0;
		decGrantWr = 1'b0;
		decMiss    = 1'b0;
		gate       = {1'b0, `PWC_SW_OK};
		if (accept)
		begin
			decRespond = 1'b1;
			case (cmdIns)
				`PWC_INS_VERIFY:
				begin
					// Verify works on the NDEF file only.
					if (fileSel != pwc_pkg::PWC_FILE_NDEF)
						decSw = `PWC_SW_COND_USE;
					else if ((cmdP1p2 != `PWC_PW_READ) && (cmdP1p2 != `PWC_PW_WRITE))
						decSw = `PWC_SW_BAD_P1P2;
					else if (cmdLc == `PWC_LC_NONE)
					begin
						// Empty verify only asks whether a password is needed.
						if ((cmdP1p2 == `PWC_PW_READ) ? readProt_ff : writeProt_ff)
							decSw = `PWC_SW_PW_REQ;
					end
					else if (cmdLc != `PWC_LC_PW)
						decSw = `PWC_SW_BAD_DATA;
					else if (retries_ff == 2'h0)
						decSw = `PWC_SW_RETRY_BASE;
					else if (cmdData == ((cmdP1p2 == `PWC_PW_READ) ? readPw_ff : writePw_ff))
					begin
						decGrantRd = (cmdP1p2 == `PWC_PW_READ);
						decGrantWr = (cmdP1p2 == `PWC_PW_WRITE);
					end
					else
					begin
						decMiss = 1'b1;
						decSw   = `PWC_SW_RETRY_BASE | {14'h0000, retries_ff - 2'h1};
					end
				end
				`PWC_INS_CHANGE:
				begin
					gate = pwc_gate_check(fileSel, writeGrant_ff, `PWC_SW_BAD_STRUCT);
					if (gate[16])
						decSw = gate[15:0];
					else if ((cmdP1p2 != `PWC_PW_READ) && (cmdP1p2 != `PWC_PW_WRITE))
						decSw = `PWC_SW_BAD_P1P2;
					else if (cmdLc != `PWC_LC_PW)
						decSw = `PWC_SW_BAD_DATA;
					else
					begin
						// The whole data field becomes the new password.
						decRespond = 1'b0;
						decNvm     = 1'b1;
						decKind    = (cmdP1p2 == `PWC_PW_READ) ? `PWC_NVM_RDPW : `PWC_NVM_WRPW;
					end
				end
				`PWC_INS_ENABLE:
				begin
					gate = pwc_gate_check(fileSel, writeGrant_ff, `PWC_SW_BAD_STRUCT);
					if (gate[16])
						decSw = gate[15:0];
					else if (cmdLc != `PWC_LC_NONE)
						decSw = `PWC_SW_BAD_DATA;
					else if ((cmdP1p2[4:0] != `PWC_SEL5_READ) && (cmdP1p2[4:0] != `PWC_SEL5_WRITE))
						decSw = `PWC_SW_BAD_P1P2;
					else
					begin
						decRdProt = readProt_ff || (cmdP1p2[4:0] == `PWC_SEL5_READ);
						decWrProt = writeProt_ff || (cmdP1p2[4:0] == `PWC_SEL5_WRITE);
						// Already protected: nothing to write, answer at once.
						if ((decRdProt != readProt_ff) || (decWrProt != writeProt_ff))
						begin
							decRespond = 1'b0;
							decNvm     = 1'b1;
							decKind    = `PWC_NVM_RIGHTS;
							decWait    = ENABLE_WAIT;
						end
					end
				end
				`PWC_INS_DISABLE:
				begin
					gate = pwc_gate_check(fileSel, writeGrant_ff, `PWC_SW_BAD_DATA);
					if (gate[16])
						decSw = gate[15:0];
					else if ((cmdP1p2 != `PWC_PW_READ) && (cmdP1p2 != `PWC_PW_WRITE))
						decSw = `PWC_SW_BAD_P1P2;
					else if (cmdLc != `PWC_LC_NONE)
						decSw = `PWC_SW_BAD_DATA;
					else
					begin
						decRdProt = readProt_ff && (cmdP1p2 != `PWC_PW_READ);
						decWrProt = writeProt_ff && (cmdP1p2 != `PWC_PW_WRITE);
						if ((decRdProt != readProt_ff) || (decWrProt != writeProt_ff))
						begin
							decRespond = 1'b0;
							decNvm     = 1'b1;
							decKind    = `PWC_NVM_RIGHTS;
							decWait    = DISABLE_WAIT;
						end
					end
				end
				default:
				begin
					decRespond = 1'b0;
				end
			endcase
		end
	end

	// The least response time runs alongside the write itself.
	pwc_delay_timer #(
		.W       (20)
	) u_wait (
		.clk     (clk),
		.rst     (rst),
		.start   (decNvm),
		.loadVal (decWait),
		.expired (timerExpired)
	);

	// Sequencer: idle, waiting for the write, then holding until the response time is up.
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			pwc_pkg::PWC_ST_IDLE:
			begin
				if (decNvm)
					nxt_state = pwc_pkg::PWC_ST_NVM;
			end
			pwc_pkg::PWC_ST_NVM:
			begin
				// A failed write answers at once; the response time only matters on success.
				if (nvmDone && nvmFail)
					nxt_state = pwc_pkg::PWC_ST_IDLE;
				else if (nvmDone)
					nxt_state = pwc_pkg::PWC_ST_HOLD;
			end
			pwc_pkg::PWC_ST_HOLD:
			begin
				if (timerExpired)
					nxt_state = pwc_pkg::PWC_ST_IDLE;
			end
			default:
			begin
				nxt_state = pwc_pkg::PWC_ST_IDLE;
			end
		endcase
	end

	// State register and command readiness; ready drops the cycle after a write starts.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_ff    <= pwc_pkg::PWC_ST_IDLE;
			cmdReady_ff <= 1'b1;
		end
		else
		begin
			state_ff    <= nxt_state;
			cmdReady_ff <= (nxt_state == pwc_pkg::PWC_ST_IDLE);
		end
	end

	// Response pulse: immediate answers, write failures and completed updates.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rspValid_ff <= 1'b0;
			rspSw_ff    <= `PWC_SW_OK;
		end
		else if (decRespond)
		begin
			rspValid_ff <= 1'b1;
			rspSw_ff    <= decSw;
		end
		else if ((state_ff == pwc_pkg::PWC_ST_NVM) && nvmDone && nvmFail)
		begin
			rspValid_ff <= 1'b1;
			rspSw_ff    <= `PWC_SW_UPD_FAIL;
		end
		else if ((state_ff == pwc_pkg::PWC_ST_HOLD) && timerExpired)
		begin
			rspValid_ff <= 1'b1;
			rspSw_ff    <= `PWC_SW_OK;
		end
		else
			rspValid_ff <= 1'b0;
	end

	// Write request: the pending values stay on the port until the next write.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			nvmReq_ff    <= 1'b0;
			nvmKind_ff   <= `PWC_NVM_RDPW;
			nvmData_ff   <= '0;
			nvmRdProt_ff <= INIT_READ_PROT;
			nvmWrProt_ff <= INIT_WRITE_PROT;
		end
		else
		begin
			nvmReq_ff <= decNvm;
			if (decNvm)
			begin
				nvmKind_ff   <= decKind;
				nvmData_ff   <= cmdData;
				nvmRdProt_ff <= decRdProt;
				nvmWrProt_ff <= decWrProt;
			end
		end
	end

	// Stored data changes only when the write reports success, so a failure keeps it.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			readPw_ff    <= INIT_READ_PW;
			writePw_ff   <= INIT_WRITE_PW;
			readProt_ff  <= INIT_READ_PROT;
			writeProt_ff <= INIT_WRITE_PROT;
		end
		else if ((state_ff == pwc_pkg::PWC_ST_NVM) && nvmDone && !nvmFail)
		begin
			if (nvmKind_ff == `PWC_NVM_RDPW)
				readPw_ff <= nvmData_ff;
			else if (nvmKind_ff == `PWC_NVM_WRPW)
				writePw_ff <= nvmData_ff;
			else
			begin
				readProt_ff  <= nvmRdProt_ff;
				writeProt_ff <= nvmWrProt_ff;
			end
		end
	end

	// Session grants: a match in the same cycle as a new session still counts.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			readGrant_ff  <= 1'b0;
			writeGrant_ff <= 1'b0;
		end
		else
		begin
			readGrant_ff  <= decGrantRd || (readGrant_ff && !sessionStart);
			writeGrant_ff <= decGrantWr || (writeGrant_ff && !sessionStart);
		end
	end

	// Attempt counter: refilled by each new session, one lost per wrong password.
	always_ff @(posedge clk)
	begin
		if (rst)
			retries_ff <= `PWC_RETRIES;
		else if (sessionStart)
			retries_ff <= `PWC_RETRIES;
		else if (decMiss)
			retries_ff <= retries_ff - 2'h1;
	end

	assign cmdReady       = cmdReady_ff;
	assign rspValid       = rspValid_ff;
	assign rspSw          = rspSw_ff;
	assign nvmReq         = nvmReq_ff;
	assign nvmKind        = nvmKind_ff;
	assign nvmData        = nvmData_ff;
	assign nvmReadProt    = nvmRdProt_ff;
	assign nvmWriteProt   = nvmWrProt_ff;
	assign readProtected  = readProt_ff;
	assign writeProtected = writeProt_ff;
	assign readGranted    = readGrant_ff;
	assign writeGranted   = writeGrant_ff;

endmodule

`default_nettype wire

// ===== pwc_nvm_model.sv
`timescale 1ns/1ps
`default_nettype none

// Non-volatile store behind the handler: it finishes each write after a short or a long
// delay, and it fails a write only when the bench asks for it.
module pwc_nvm_model (
	// Clock and reset.
	input  wire logic clk,
	input  wire logic rst,
	// Write port of the handler.
	input  wire logic nvmReq,
	output logic      nvmDone,
	output logic      nvmFail,
	// Bench control.
	input  wire logic failNext,
	input  wire logic slow
);
	logic [5:0] left_ff;    // Edges still to wait before the write ends.
	logic       busy_ff;    // A write is in progress.
	logic       failVal_ff; // Outcome chosen when the write began.

	// The slow delay outlasts both protection waits, so the late completion path is used too.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			busy_ff    <= 1'b0;
			nvmDone    <= 1'b0;
			left_ff    <= 6'h00;
			failVal_ff <= 1'b0;
		end
		else
		begin
			nvmDone <= 1'b0;
			if (nvmReq)
			begin
				busy_ff    <= 1'b1;
				left_ff    <= slow ? 6'h28 : 6'h02;
				failVal_ff <= failNext;
			end
			else if (busy_ff && left_ff == 6'h00)
			begin
				busy_ff <= 1'b0;
				nvmDone <= 1'b1;
			end
			else if (busy_ff)
				left_ff <= left_ff - 6'h01;
		end
	end

	// Outside the done pulse the fail line shows the inverse, so nothing may lean on it there.
	assign nvmFail = nvmDone ? failVal_ff : ~failVal_ff;
endmodule
`default_nettype wire

// ===== pwc_pw_access_cmd_checker.sv
`timescale 1ns/1ps
`default_nettype none

// Ties answers to change, enable and disable commands and their writes to the command that caused them.
module pwc_pw_access_cmd_checker #(
	parameter int unsigned ENABLE_CYCLES  = 20,
	parameter int unsigned DISABLE_CYCLES = 30
) (
	// Clock and reset.
	input  wire logic                  clk,
	input  wire logic                  rst,
	// Command side.
	input  wire pwc_pkg::pwc_file_type fileSel,
	input  wire logic                  cmdValid,
	input  wire logic [7:0]            cmdCla,
	input  wire logic [7:0]            cmdIns,
	input  wire logic [15:0]           cmdP1p2,
	input  wire logic [7:0]            cmdLc,
	input  wire logic [127:0]          cmdData,
	input  wire logic                  cmdReady,
	// Answers, write port and state.
	input  wire logic                  rspValid,
	input  wire logic [15:0]           rspSw,
	input  wire logic                  nvmReq,
	input  wire logic [1:0]            nvmKind,
	input  wire logic [127:0]          nvmData,
	input  wire logic                  nvmReadProt,
	input  wire logic                  nvmDone,
	input  wire logic                  nvmFail,
	input  wire logic                  readProtected,
	input  wire logic                  writeGranted
);
	logic        take;       // A class-00 command of any instruction is taken at this edge.
	logic        ndefOk;     // NDEF file selected and write password verified.
	logic        otherFile;  // Container or system file selected.
	logic [19:0] waitCnt_ff; // Edges since the last taken command.
	logic [7:0]  lastIns_ff; // Instruction of the last taken command.
	logic        pend_ff;    // A non-volatile write is outstanding.

	assign take      = cmdValid && cmdReady && cmdCla == 8'h00;
	assign ndefOk    = fileSel == pwc_pkg::PWC_FILE_NDEF && writeGranted;
	assign otherFile = fileSel == pwc_pkg::PWC_FILE_CC || fileSel == pwc_pkg::PWC_FILE_SYS;

	// Measures the answer delay; twenty bits outlast the run, so no saturation is needed.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			waitCnt_ff <= 20'h0_0000;
			lastIns_ff <= 8'h00;
			pend_ff    <= 1'b0;
		end
		else
		begin
			waitCnt_ff <= take ? 20'h0_0001 : waitCnt_ff + 20'h0_0001;
			if (take)
				lastIns_ff <= cmdIns;
			pend_ff <= nvmReq | (pend_ff & ~rspValid);
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// A command taken, and an answer carrying a status word.
	sequence s_take(logic [7:0] ins);
		take && cmdIns == ins;
	endsequence
	sequence s_answer(logic [15:0] sw);
		rspValid && rspSw == sw;
	endsequence

	property p_no_file;
		s_take(8'h24) ##0 fileSel == pwc_pkg::PWC_FILE_NONE |=> s_answer(16'h6A82);
	endproperty
	property p_bad_struct;
		s_take(8'h24) ##0 otherFile |=> s_answer(16'h6981);
	endproperty
	property p_dis_file;
		s_take(8'h26) ##0 otherFile |=> s_answer(16'h6A80);
	endproperty
	property p_security;
		take && cmdIns inside {8'h24, 8'h26, 8'h28} && fileSel == pwc_pkg::PWC_FILE_NDEF
			&& !writeGranted |=> s_answer(16'h6982) ##0 !nvmReq;
	endproperty
	property p_bad_p1p2;
		s_take(8'h24) ##0 (ndefOk && cmdP1p2 != 16'h0001 && cmdP1p2 != 16'h0002)
			|=> s_answer(16'h6A86);
	endproperty
	property p_change;
		s_take(8'h24) ##0 (ndefOk && cmdLc == 8'h10 && cmdP1p2 inside {16'h0001, 16'h0002})
			|=> nvmReq && nvmData == $past(cmdData)
			&& nvmKind == {1'b0, $past(cmdP1p2) == 16'h0002};
	endproperty
	property p_enable;
		s_take(8'h28) ##0 (ndefOk && cmdLc == 8'h00 && cmdP1p2[4:0] == 5'h01 && !readProtected)
			|=> nvmReq && nvmKind == 2'h2 && nvmReadProt;
	endproperty
	property p_fail;
		nvmDone && nvmFail |=> s_answer(16'h6581) ##0 cmdReady;
	endproperty
	property p_ok;
		nvmDone && !nvmFail |-> ##[1:40] s_answer(16'h9000);
	endproperty
	property p_en_wait;
		rspValid && rspSw == 16'h9000 && pend_ff && lastIns_ff == 8'h28
			|-> waitCnt_ff > ENABLE_CYCLES;
	endproperty
	property p_dis_wait;
		rspValid && rspSw == 16'h9000 && pend_ff && lastIns_ff == 8'h26
			|-> waitCnt_ff > DISABLE_CYCLES;
	endproperty

	a_no_file: assert property (p_no_file)
		else $error("change without a file was not answered 6A82");
	a_bad_struct: assert property (p_bad_struct)
		else $error("change on a wrong file was not answered 6981");
	a_dis_file: assert property (p_dis_file)
		else $error("disable on a wrong file was not answered 6A80");
	a_security: assert property (p_security)
		else $error("command without grant was not refused with 6982");
	a_bad_p1p2: assert property (p_bad_p1p2)
		else $error("change with reserved parameters was not answered 6A86");
	a_change: assert property (p_change)
		else $error("change did not write the new password");
	a_enable: assert property (p_enable)
		else $error("enable did not write read protection");
	a_fail: assert property (p_fail)
		else $error("failed write was not answered 6581");
	a_ok: assert property (p_ok)
		else $error("finished write was not answered 9000");
	a_en_wait: assert property (p_en_wait)
		else $error("enable answered too early");
	a_dis_wait: assert property (p_dis_wait)
		else $error("disable answered too early");
endmodule

bind pwc_pw_access_cmd pwc_pw_access_cmd_checker #(
	.ENABLE_CYCLES(ENABLE_CYCLES),
	.DISABLE_CYCLES(DISABLE_CYCLES)
) chk (.clk(clk), .rst(rst), .fileSel(fileSel), .cmdValid(cmdValid), .cmdCla(cmdCla),
	.cmdIns(cmdIns), .cmdP1p2(cmdP1p2), .cmdLc(cmdLc), .cmdData(cmdData),
	.cmdReady(cmdReady), .rspValid(rspValid), .rspSw(rspSw), .nvmReq(nvmReq),
	.nvmKind(nvmKind), .nvmData(nvmData), .nvmReadProt(nvmReadProt), .nvmDone(nvmDone),
	.nvmFail(nvmFail), .readProtected(readProtected), .writeGranted(writeGranted));
`default_nettype wire

// ===== pwc_pw_access_cmd_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

// Drives commands as the reader would and checks every status word in order.
module pwc_pw_access_cmd_tb_top;
	localparam logic [127:0] WPW = 128'h5a5a; // Write password at boot; value is arbitrary.
	logic                  clk = 0, rst = 1, sessionStart = 0, cmdValid = 0;
	logic                  failNext = 0, slow = 0;       // Store behaviour for the next write.
	pwc_pkg::pwc_file_type fileSel = pwc_pkg::PWC_FILE_NONE;
	logic [7:0]            cmdCla = 0, cmdIns = 0, cmdLc = 0;
	logic [15:0]           cmdP1p2 = 0, rspSw;
	logic [127:0]          cmdData = 0, nvmData, pw = 0;
	logic [1:0]            nvmKind;
	logic                  cmdReady, rspValid, nvmReq, nvmReadProt, nvmWriteProt;
	logic                  nvmDone, nvmFail, readProtected, writeProtected;
	logic                  readGranted, writeGranted;
	int                    mismatches = 0, samples_checked = 0;
	logic [15:0]           expQ[$];                      // Status words still awaited.
	logic [31:0]           seed = 32'h464b;
	logic [7:0]            insTab [3] = '{8'h24, 8'h26, 8'h28};

	// Short protection waits keep the run brief; the checker gets the same figures.
	pwc_pw_access_cmd #(.ENABLE_CYCLES(20), .DISABLE_CYCLES(30), .INIT_WRITE_PW(WPW)) uut (
		.clk(clk), .rst(rst), .sessionStart(sessionStart), .fileSel(fileSel),
		.cmdValid(cmdValid), .cmdCla(cmdCla), .cmdIns(cmdIns), .cmdP1p2(cmdP1p2),
		.cmdLc(cmdLc), .cmdData(cmdData), .cmdReady(cmdReady), .rspValid(rspValid),
		.rspSw(rspSw), .nvmReq(nvmReq), .nvmKind(nvmKind), .nvmData(nvmData),
		.nvmReadProt(nvmReadProt), .nvmWriteProt(nvmWriteProt), .nvmDone(nvmDone),
		.nvmFail(nvmFail), .readProtected(readProtected), .writeProtected(writeProtected),
		.readGranted(readGranted), .writeGranted(writeGranted));
	pwc_nvm_model nvm (.clk(clk), .rst(rst), .nvmReq(nvmReq), .nvmDone(nvmDone),
		.nvmFail(nvmFail), .failNext(failNext), .slow(slow));

	always #10 clk = ~clk;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic chk(input string n, input logic [127:0] e, input logic [127:0] g);
		samples_checked++;
		if (g !== e)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask

	// Presents one command at the falling edge and notes its answer; valid stays up.
	task automatic issue(input logic [7:0] ins, input logic [15:0] p, input logic [7:0] lc,
		input logic [127:0] d, input logic [15:0] sw);
		@(negedge clk);
		cmdValid = 1;
		cmdIns = ins;
		cmdP1p2 = p;
		cmdLc = lc;
		cmdData = d;
		expQ.push_back(sw);
	endtask

	// Drops valid and waits, bounded, for all answers and an idle handler.
	task automatic idle();
		int n = 0;
		@(negedge clk);
		cmdValid = 0;
		while ((expQ.size() != 0 || cmdReady !== 1'b1) && n < 200)
		begin
			@(negedge clk);
			n++;
		end
		if (n >= 200)
			chk("answer wait", 0, 1);
	endtask

	task automatic cmd(input logic [7:0] ins, input logic [15:0] p, input logic [7:0] lc,
		input logic [127:0] d, input logic [15:0] sw);
		issue(ins, p, lc, d, sw);
		idle();
	endtask

	task automatic newSession();
		@(negedge clk) sessionStart = 1;
		@(negedge clk) sessionStart = 0;
	endtask

	task automatic test_done();
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Answers are taken at the falling edge, where the registered outputs have settled.
	always @(negedge clk)
	begin
		if (rspValid === 1'b1 && expQ.size() == 0)
			chk("unexpected answer", 0, 1);
		else if (rspValid === 1'b1)
			chk("status", expQ.pop_front(), rspSw);
	end

	// Cuts a hang short well beyond the expected run length.
	initial
	begin
		repeat (20000) @(posedge clk);
		mismatches++;
		test_done();
	end

	initial
	begin
		repeat (16) @(negedge clk);
		rst = 0;
		chk("reset status", 16'h9000, rspSw);
		chk("reset state", 4'h8, {cmdReady, readProtected, writeProtected, writeGranted});
		newSession();
		$display("test reset done");
		cmd(8'h24, 16'h0001, 8'h10, 0, 16'h6A82);
		cmd(8'h26, 16'h0001, 8'h00, 0, 16'h6A82);
		fileSel = pwc_pkg::PWC_FILE_CC;
		cmd(8'h24, 16'h0001, 8'h10, 0, 16'h6981);
		cmd(8'h26, 16'h0001, 8'h00, 0, 16'h6A80);
		fileSel = pwc_pkg::PWC_FILE_SYS;
		cmd(8'h28, 16'h0001, 8'h00, 0, 16'h6981);
		cmd(8'h26, 16'h0002, 8'h00, 0, 16'h6A80);
		fileSel = pwc_pkg::PWC_FILE_NDEF;
		for (int i = 0; i < 3; i++)
			cmd(insTab[i], 16'h0001, i == 0 ? 8'h10 : 8'h00, 0, 16'h6982);
		$display("test file and security done");
		cmd(8'h20, 16'h0002, 8'h10, ~WPW, 16'h63C2);
		cmd(8'h20, 16'h0002, 8'h10, WPW, 16'h9000);
		chk("write grant", 1, writeGranted);
		// Refusals back to back, one per cycle.
		issue(8'h24, 16'h0003, 8'h10, 0, 16'h6A86);
		issue(8'h24, 16'h0001, 8'h0F, 0, 16'h6A80);
		issue(8'h28, 16'h0001, 8'h10, 0, 16'h6A80);
		issue(8'h28, 16'h0003, 8'h00, 0, 16'h6A86);
		issue(8'h26, 16'h0003, 8'h00, 0, 16'h6A86);
		idle();
		$display("test parameters done");
		repeat (4)
		begin
			seed = lfsr(seed);
			pw = {pw[95:0], seed};
		end
		cmd(8'h24, 16'h0001, 8'h10, pw, 16'h9000);
		chk("read password", {2'h0, pw}, {nvmKind, nvmData});
		cmd(8'h20, 16'h0001, 8'h10, pw, 16'h9000);
		chk("read grant", 1, readGranted);
		cmd(8'h24, 16'h0002, 8'h10, ~pw, 16'h9000);
		chk("write password", {2'h1, ~pw}, {nvmKind, nvmData});
		$display("test change done");
		for (int k = 1; k <= 2; k++)
		begin
			slow = (k == 2);
			cmd(8'h28, 16'hFFE0 | 16'(k), 8'h00, 0, 16'h9000);
			chk("protection on", 5 * k,
				{nvmWriteProt, nvmReadProt, writeProtected, readProtected});
			cmd(8'h28, 16'(k), 8'h00, 0, 16'h9000);
			cmd(8'h20, 16'(k), 8'h00, 0, 16'h6300);
			failNext = 1;
			cmd(8'h26, 16'(k), 8'h00, 0, 16'h6581);
			chk("protection kept", k, {writeProtected, readProtected});
			failNext = 0;
			cmd(8'h26, 16'(k), 8'h00, 0, 16'h9000);
			chk("protection off", 0, {writeProtected, readProtected});
			cmd(8'h20, 16'(k), 8'h00, 0, 16'h9000);
		end
		$display("test protection done");
		newSession();
		cmd(8'h24, 16'h0001, 8'h10, pw, 16'h6982);
		for (int r = 2; r >= 0; r--)
			cmd(8'h20, 16'h0002, 8'h10, WPW, 16'h63C0 | 16'(r));
		cmd(8'h20, 16'h0002, 8'h10, ~pw, 16'h63C0);
		chk("no grant", 0, writeGranted);
		$display("test session done");
		test_done();
	end
endmodule
`default_nettype wire
